// file: common/posn_pkg.sv
// Shared constants, register map and carrier types for the positioning block
package posn_pkg;
	// ****************************************
	// Sizes
	// ****************************************
	localparam int CH_N = 4;
	localparam int PIN_N = 8;
	localparam int CODE_W = 4;
	localparam int DIV_W = 8;
	// ****************************************
	// Register map (byte addresses)
	// ****************************************
	localparam logic [7:0] ADDR_SEL = 8'h00;
	localparam logic [7:0] ADDR_CTRL = 8'h04;
	localparam logic [7:0] ADDR_ISTAT = 8'h08;
	localparam logic [7:0] ADDR_ICLR = 8'h0c;
	localparam logic [7:0] ADDR_IEN = 8'h10;
	localparam logic [7:0] ADDR_STAT = 8'h14;
	localparam logic [3:0] ADDR_START_HI = 4'h2;
	localparam logic [3:0] ADDR_POS_HI = 4'h3;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// ****************************************
	// Fields and reset values
	// ****************************************
	localparam logic [15:0] SEL_RST = 16'hffff;
	localparam logic [3:0] CODE_SOFT = 4'h8;
	localparam logic [3:0] CODE_UNUSED = 4'hf;
	// Operation error code, decimal 6763
	localparam logic [15:0] ERR_OP = 16'h1a6b;
	localparam int IRQ_ERR_LSB = 4;
	localparam int IRQ_W = 2 * CH_N;
	// ****************************************
	// Timing
	// ****************************************
	localparam int CLK_PERIOD_NS = 8;
	localparam int PULSE_PERIOD_NS = 1000;
	localparam int STEP_CYC = (PULSE_PERIOD_NS / CLK_PERIOD_NS < 1) ? 1 : PULSE_PERIOD_NS / CLK_PERIOD_NS;
	localparam logic [DIV_W-1:0] STEP_LAST = DIV_W'(STEP_CYC - 1);
	// ****************************************
	// Types
	// ****************************************
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_WAIT = 2'b01,
		ST_COUNT = 2'b10
	} chan_state_t;
	typedef struct packed {
		logic en;
		logic [CODE_W-1:0] code;
	} chan_sel_t;
	typedef struct packed {
		logic busy;
		logic dir;
		logic [31:0] pos;
	} chan_stat_t;
endpackage

// file: verilog/pins_sync.sv
// Three-stage input synchroniser with agreement filter
`timescale 1ns/100ps
module pins_sync #(
	parameter int W = 1
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] s1_r, s2_r, s3_r, q_r;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s1_r <= '0;
			s2_r <= '0;
			s3_r <= '0;
			q_r <= '0;
		end else begin
			s1_r <= d;
			s2_r <= s1_r;
			s3_r <= s2_r;
			// A change counts only once two later stages agree
			q_r <= (s2_r & s3_r) | (q_r & (s2_r | s3_r));
		end
	end
	assign q = q_r;
endmodule // pins_sync

// file: verilog/posn_chan.sv
// One interrupt-positioning pulse channel
`timescale 1ns/100ps
module posn_chan #(
	parameter int CH = 0
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic step_en,
	input wire logic start,
	input wire logic [15:0] count,
	input wire posn_pkg::chan_sel_t sel,
	input wire logic [posn_pkg::PIN_N-1:0] pins,
	input wire logic soft_cmd,
	input wire logic soft_ok,
	input wire logic allowed,
	output logic pulse,
	output posn_pkg::chan_stat_t stat,
	output logic done,
	output logic err
);
	import posn_pkg::*;
	localparam logic [CODE_W-1:0] DEF_CODE = CODE_W'(CH);
	chan_state_t st_r;
	logic [CODE_W-1:0] code_r;
	logic [15:0] mag_r, rem_r;
	logic dir_r, pulse_r, done_r, err_r;
	logic [31:0] pos_r;
	wire [CODE_W-1:0] live_code = sel.en ? sel.code : DEF_CODE;
	wire live_bad = (live_code > CODE_SOFT) || (live_code == CODE_SOFT && !soft_ok)
		|| !allowed || count == 16'h0000;
	wire trig = (code_r == CODE_SOFT) ? soft_cmd : pins[code_r[2:0]];
	wire [15:0] mag = count[15] ? 16'(-count) : count;
	wire moving = st_r != ST_IDLE;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_r <= ST_IDLE;
			code_r <= CODE_UNUSED;
			mag_r <= 16'h0000;
			rem_r <= 16'h0000;
			dir_r <= 1'b0;
			pos_r <= 32'h0000_0000;
			pulse_r <= 1'b0;
			done_r <= 1'b0;
			err_r <= 1'b0;
		end else begin
			done_r <= 1'b0;
			err_r <= 1'b0;
			pulse_r <= step_en && moving;
			if (step_en && moving)
				pos_r <= dir_r ? pos_r + 32'h1 : pos_r - 32'h1;
			case (st_r)
				ST_IDLE: if (start) begin
					if (live_bad) begin
						err_r <= 1'b1;
					end else begin
						st_r <= ST_WAIT;
						code_r <= live_code;
						mag_r <= mag;
						dir_r <= !count[15];
					end
				end
				// Level trigger, so an input already on at start acts at once
				ST_WAIT: if (trig) begin
					st_r <= ST_COUNT;
					rem_r <= mag_r;
				end
				ST_COUNT: if (step_en) begin
					rem_r <= rem_r - 16'h1;
					if (rem_r == 16'h1) begin
						st_r <= ST_IDLE;
						done_r <= 1'b1;
					end
				end
				default: st_r <= ST_IDLE;
			endcase
		end
	end
	assign pulse = pulse_r;
	assign done = done_r;
	assign err = err_r;
	assign stat = '{busy: moving, dir: dir_r, pos: pos_r};
endmodule // posn_chan

// file: verilog/posn_ctrl.sv
// Interrupt-positioning controller: register slave, trigger routing and four pulse channels
`timescale 1ns/100ps
// Summary of operation
// - Direction of channels 0..3 appears on pin_out4..pin_out7.
// - Positive count moves forward; each pulse increments position.
// - Negative count moves reverse; each pulse decrements position.
// - Direction output high forward, low reverse.
// - Select enabled: each channel uses its own selector field.
// - Codes 0..7 pick pin_in0..pin_in7 as trigger.
// - Code 8 picks the channel's software command bit.
// - Code F marks the channel unused; a start there is refused.
// - Start with code 9..E flags operation error and emits no pulses.
// - Code 8 without software-command support flags error, no motion.
// - Channel 3 works only with the second adapter present.
// - Channel 0 uses selector bits 3:0.
// - After trigger, emit count magnitude pulses, stop, flag completion.
module posn_ctrl #(
	parameter logic SOFT_CMD_OK = 1'b1
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [7:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	input wire logic [posn_pkg::PIN_N-1:0] pin_in,
	input wire logic dual_adapter,
	output logic [posn_pkg::CH_N-1:0] pulse_out,
	output logic pin_out4,
	output logic pin_out5,
	output logic pin_out6,
	output logic pin_out7,
	output logic irq
);
	import posn_pkg::*;

	// ****************************************
	// Write channel
	// ****************************************
	logic aw_have_r, w_have_r, bvalid_r;
	logic [1:0] bresp_r;
	logic [7:0] awaddr_r;
	logic [31:0] wdata_r;
	logic [3:0] wstrb_r;
	wire wr_fire = aw_have_r && w_have_r && !bvalid_r;
	wire [3:0] wa_hi = awaddr_r[7:4];
	wire [1:0] wa_ch = awaddr_r[3:2];
	wire wr_sel = wr_fire && awaddr_r == ADDR_SEL;
	wire wr_ctrl = wr_fire && awaddr_r == ADDR_CTRL;
	wire wr_iclr = wr_fire && awaddr_r == ADDR_ICLR;
	wire wr_ien = wr_fire && awaddr_r == ADDR_IEN;
	wire wr_start = wr_fire && wa_hi == ADDR_START_HI && awaddr_r[1:0] == 2'b00;
	wire wr_ok = wr_sel || wr_ctrl || wr_iclr || wr_ien || wr_start;
	// Counts need both low lanes; a half-written count would start a wrong move
	wire start_lanes = wstrb_r[1:0] == 2'b11;

	assign awready = !aw_have_r && !bvalid_r;
	assign wready = !w_have_r && !bvalid_r;
	assign bvalid = bvalid_r;
	assign bresp = bresp_r;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_have_r <= 1'b0;
			w_have_r <= 1'b0;
			bvalid_r <= 1'b0;
			bresp_r <= RESP_OKAY;
			awaddr_r <= 8'h00;
			wdata_r <= 32'h0000_0000;
			wstrb_r <= 4'h0;
		end else begin
			if (awvalid && awready) begin
				aw_have_r <= 1'b1;
				awaddr_r <= awaddr;
			end
			if (wvalid && wready) begin
				w_have_r <= 1'b1;
				wdata_r <= wdata;
				wstrb_r <= wstrb;
			end
			if (wr_fire) begin
				aw_have_r <= 1'b0;
				w_have_r <= 1'b0;
				bvalid_r <= 1'b1;
				bresp_r <= wr_ok ? RESP_OKAY : RESP_SLVERR;
			end else if (bvalid_r && bready) begin
				bvalid_r <= 1'b0;
			end
		end
	end

	// ****************************************
	// Control registers
	// ****************************************
	logic [15:0] sel_r;
	logic en_r;
	logic [CH_N-1:0] soft_r;
	logic [IRQ_W-1:0] ien_r, istat_r;
	logic [15:0] errcode_r;
	logic [CH_N-1:0][15:0] cnt_r;
	logic [CH_N-1:0] start_v, busy_v, dir_v, done_v, err_v;
	chan_stat_t [CH_N-1:0] stat;
	logic [PIN_N-1:0] pins_s;
	logic dual_s;

	wire [15:0] sel_nxt = {wstrb_r[1] ? wdata_r[15:8] : sel_r[15:8], wstrb_r[0] ? wdata_r[7:0] : sel_r[7:0]};
	wire [IRQ_W-1:0] clr_mask = (wr_iclr && wstrb_r[0]) ? wdata_r[IRQ_W-1:0] : {IRQ_W{1'b0}};
	// A new event in the clearing cycle survives the clear
	wire [IRQ_W-1:0] istat_nxt = (istat_r & ~clr_mask) | {err_v, done_v};
	wire err_cleared = |clr_mask[IRQ_W-1:IRQ_ERR_LSB];
	wire [15:0] errcode_nxt = (|err_v) ? ERR_OP : err_cleared ? 16'h0000 : errcode_r;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sel_r <= SEL_RST;
			en_r <= 1'b0;
			soft_r <= {CH_N{1'b0}};
			ien_r <= {IRQ_W{1'b0}};
			istat_r <= {IRQ_W{1'b0}};
			errcode_r <= 16'h0000;
		end else begin
			if (wr_sel)
				sel_r <= sel_nxt;
			if (wr_ctrl && wstrb_r[0]) begin
				en_r <= wdata_r[0];
				soft_r <= wdata_r[CH_N:1];
			end
			if (wr_ien && wstrb_r[0])
				ien_r <= wdata_r[IRQ_W-1:0];
			istat_r <= istat_nxt;
			errcode_r <= errcode_nxt;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cnt_r <= '0;
		end else begin
			for (int i = 0; i < CH_N; i++) begin
				if (start_v[i])
					cnt_r[i] <= wdata_r[15:0];
			end
		end
	end

	assign irq = |(istat_r & ien_r);

	// ****************************************
	// Step divider and input synchroniser
	// ****************************************
	logic [DIV_W-1:0] div_r;
	wire step_en = div_r == STEP_LAST;
	always_ff @(posedge aclk) begin
		if (!aresetn)
			div_r <= '0;
		else
			div_r <= step_en ? '0 : div_r + DIV_W'(1);
	end

	pins_sync #(
		.W(PIN_N + 1)
	) u_sync (
		.aclk(aclk),
		.aresetn(aresetn),
		.d({dual_adapter, pin_in}),
		.q({dual_s, pins_s})
	);

	// ****************************************
	// Channels
	// ****************************************
	generate
		for (genvar c = 0; c < CH_N; c++) begin : g_ch
			localparam logic IS_LAST = (c == CH_N - 1);
			chan_sel_t sel_c;
			assign sel_c = '{en: en_r, code: sel_r[c*CODE_W +: CODE_W]};
			// Starts while busy are dropped so a running move keeps its operands
			assign start_v[c] = wr_start && start_lanes && wa_ch == 2'(c) && !busy_v[c];
			assign busy_v[c] = stat[c].busy;
			assign dir_v[c] = stat[c].dir;
			posn_chan #(
				.CH(c)
			) u_chan (
				.aclk(aclk),
				.aresetn(aresetn),
				.step_en(step_en),
				.start(start_v[c]),
				.count(wdata_r[15:0]),
				.sel(sel_c),
				.pins(pins_s),
				.soft_cmd(soft_r[c]),
				.soft_ok(SOFT_CMD_OK),
				.allowed(!IS_LAST || dual_s),
				.pulse(pulse_out[c]),
				.stat(stat[c]),
				.done(done_v[c]),
				.err(err_v[c])
			);
		end
	endgenerate

	// Direction pins stay owned by the channels for the whole move
	assign pin_out4 = dir_v[0];
	assign pin_out5 = dir_v[1];
	assign pin_out6 = dir_v[2];
	assign pin_out7 = dir_v[3];

	// ****************************************
	// Read channel
	// ****************************************
	logic rvalid_r;
	logic [1:0] rresp_r;
	logic [31:0] rdata_r;
	wire [3:0] ra_hi = araddr[7:4];
	wire [1:0] ra_ch = araddr[3:2];
	wire ra_al = araddr[1:0] == 2'b00;
	wire ra_sel = araddr == ADDR_SEL;
	wire ra_ctrl = araddr == ADDR_CTRL;
	wire ra_istat = araddr == ADDR_ISTAT;
	wire ra_iclr = araddr == ADDR_ICLR;
	wire ra_ien = araddr == ADDR_IEN;
	wire ra_stat = araddr == ADDR_STAT;
	wire ra_start = ra_hi == ADDR_START_HI && ra_al;
	wire ra_pos = ra_hi == ADDR_POS_HI && ra_al;
	wire ra_ok = ra_sel || ra_ctrl || ra_istat || ra_iclr || ra_ien || ra_stat || ra_start || ra_pos;
	wire [31:0] rd_data =
		ra_sel ? {16'h0000, sel_r} :
		ra_ctrl ? {26'h0, dual_s, soft_r, en_r} :
		ra_istat ? {24'h0, istat_r} :
		ra_ien ? {24'h0, ien_r} :
		ra_stat ? {errcode_r, 8'h00, dir_v, busy_v} :
		ra_start ? {16'h0000, cnt_r[ra_ch]} :
		ra_pos ? stat[ra_ch].pos :
		32'h0000_0000;

	assign arready = !rvalid_r;
	assign rvalid = rvalid_r;
	assign rdata = rdata_r;
	assign rresp = rresp_r;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_r <= 1'b0;
			rresp_r <= RESP_OKAY;
			rdata_r <= 32'h0000_0000;
		end else if (arvalid && arready) begin
			rvalid_r <= 1'b1;
			rdata_r <= rd_data;
			rresp_r <= ra_ok ? RESP_OKAY : RESP_SLVERR;
		end else if (rvalid_r && rready) begin
			rvalid_r <= 1'b0;
		end
	end

	// ****************************************
	// Assertions
	// ****************************************
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	// Channel 1 carries the illegal-code sweep, so its refusal is the one worth watching
	wire ch1_bad_code = en_r && sel_r[7:4] > CODE_SOFT && sel_r[7:4] != CODE_UNUSED;

	sequence s_start1_bad;
		start_v[1] && ch1_bad_code;
	endsequence
	sequence s_refused1;
		err_v[1] && !busy_v[1] ##1 istat_r[IRQ_ERR_LSB + 1] && errcode_r == ERR_OP;
	endsequence
	sequence s_start0_soft;
		start_v[0] && en_r && sel_r[3:0] == CODE_SOFT && wdata_r[15:0] != 16'h0000;
	endsequence

	property p_fwd_step;
		pulse_out[0] && dir_v[0] |-> stat[0].pos == $past(stat[0].pos) + 32'h1;
	endproperty
	a_fwd_step: assert property (p_fwd_step) else $error("forward pulse did not raise position");

	property p_rev_step;
		pulse_out[1] && !dir_v[1] |-> stat[1].pos == $past(stat[1].pos) - 32'h1;
	endproperty
	a_rev_step: assert property (p_rev_step) else $error("reverse pulse did not lower position");

	property p_dir_sign;
		$rose(busy_v[0]) |-> pin_out4 == !cnt_r[0][15];
	endproperty
	a_dir_sign: assert property (p_dir_sign) else $error("direction does not follow count sign");

	property p_bad_code;
		s_start1_bad |=> s_refused1 ##0 !busy_v[1][*3];
	endproperty
	a_bad_code: assert property (p_bad_code) else $error("bad selector code not refused");

	property p_soft_unsupported;
		start_v[0] && en_r && sel_r[3:0] == CODE_SOFT && !SOFT_CMD_OK |=> err_v[0] && !busy_v[0];
	endproperty
	a_soft_unsupported: assert property (p_soft_unsupported) else $error("soft code accepted on old revision");

	property p_soft_start;
		s_start0_soft and SOFT_CMD_OK |=> busy_v[0] && !err_v[0];
	endproperty
	a_soft_start: assert property (p_soft_start) else $error("soft trigger code failed to start");

	property p_ch3_gate;
		start_v[3] && !dual_s |=> !busy_v[3] && err_v[3];
	endproperty
	a_ch3_gate: assert property (p_ch3_gate) else $error("channel 3 ran without second adapter");

	property p_quiet_idle;
		!$past(busy_v[2]) |-> !pulse_out[2];
	endproperty
	a_quiet_idle: assert property (p_quiet_idle) else $error("pulse emitted while idle");

	property p_done_stops;
		done_v[0] |-> !busy_v[0] && pulse_out[0] ##1 istat_r[0];
	endproperty
	a_done_stops: assert property (p_done_stops) else $error("completion without stop or flag");

	property p_sticky;
		istat_r[0] && !clr_mask[0] |=> istat_r[0];
	endproperty
	a_sticky: assert property (p_sticky) else $error("status bit lost without clear");

	property p_sel_held;
		busy_v[1] && $past(busy_v[1]) |-> $stable(g_ch[1].u_chan.code_r) && $stable(dir_v[1]);
	endproperty
	a_sel_held: assert property (p_sel_held) else $error("selector change disturbed a running move");

endmodule // posn_ctrl

// file: tb/drive_model.sv
// Far-side drive model: counts step pulses and tracks position from direction
`timescale 1ns/100ps
module drive_model (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [3:0] step,
	input wire logic [3:0] dir
);
	int cnt [4];
	int pos [4];
	// ****************************************
	// Step counting
	// ****************************************
	// Direction pins are only read as direction, never reused during a move
	always_ff @(posedge aclk) begin
		for (int i = 0; i < 4; i++) begin
			if (!aresetn) begin
				cnt[i] <= 0;
				pos[i] <= 0;
			end else if (step[i]) begin
				cnt[i] <= cnt[i] + 1;
				pos[i] <= pos[i] + (dir[i] ? 1 : -1);
			end
		end
	end
endmodule // drive_model

// file: tb/tb_top.sv
// Self-checking bench for the interrupt-positioning controller
`timescale 1ns/100ps
module tb_top;
	import posn_pkg::*;
	logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
	logic arvalid, arready, rvalid, rready, dual_adapter, irq;
	logic pin_out4, pin_out5, pin_out6, pin_out7;
	logic [7:0] awaddr, araddr, pin_in;
	logic [31:0] wdata, rdata, rv;
	logic [3:0] wstrb, pulse_out;
	logic [1:0] bresp, rresp, rs;
	wire [3:0] dir_w = {pin_out7, pin_out6, pin_out5, pin_out4};
	int bad_count, n_compared, cyc;
	posn_ctrl #(.SOFT_CMD_OK(1'b1)) uut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
		.awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
		.bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
		.rresp(rresp), .rvalid(rvalid), .rready(rready), .pin_in(pin_in), .dual_adapter(dual_adapter),
		.pulse_out(pulse_out), .pin_out4(pin_out4), .pin_out5(pin_out5), .pin_out6(pin_out6),
		.pin_out7(pin_out7), .irq(irq));
	// Old revision without software command, driven in step with uut; its assertions judge it
	posn_ctrl #(.SOFT_CMD_OK(1'b0)) uut_old (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
		.awready(), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(), .bresp(), .bvalid(), .bready(bready),
		.araddr(araddr), .arvalid(arvalid), .arready(), .rdata(), .rresp(), .rvalid(), .rready(rready),
		.pin_in(pin_in), .dual_adapter(dual_adapter), .pulse_out(), .pin_out4(), .pin_out5(), .pin_out6(),
		.pin_out7(), .irq());
	drive_model dm (.aclk(aclk), .aresetn(aresetn), .step(pulse_out), .dir(dir_w));
	// ****************************************
	// Helpers
	// ****************************************
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			bad_count++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		bit fin;
		fin = 0;
		awaddr <= a;
		wdata <= d;
		wstrb <= 4'hf;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!fin) begin
			@(posedge aclk);
			if (awvalid && awready)
				awvalid <= 1'b0;
			if (wvalid && wready)
				wvalid <= 1'b0;
			if (bvalid) begin
				r = bresp;
				bready <= 1'b0;
				fin = 1;
			end
		end
		// Idle edge so the next call never raises bready in the step that lowered it
		@(posedge aclk);
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		bit fin;
		fin = 0;
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		while (!fin) begin
			@(posedge aclk);
			if (arvalid && arready)
				arvalid <= 1'b0;
			if (rvalid) begin
				d = rdata;
				r = rresp;
				rready <= 1'b0;
				fin = 1;
			end
		end
		@(posedge aclk);
	endtask
	// Polling is bounded; the cycle ceiling still guards a stuck bus
	task automatic wait_bit(input int b);
		for (int i = 0; i < 400; i++) begin
			rd(ADDR_ISTAT, rv, rs);
			if (rv[b] === 1'b1)
				break;
		end
		chk(rv[b], 1'b1);
	endtask
	// Start a move, trigger it right after a pre-trigger pulse, then judge it
	task automatic move(input int ch, input logic signed [15:0] n, input int src, input logic en, input logic scr);
		int snap;
		logic [31:0] cw;
		cw = {31'h0, en};
		wr(ADDR_CTRL, cw, rs);
		wr(8'h20 + 8'(4 * ch), {16'h0, n}, rs);
		if (scr)
			wr(ADDR_SEL, 32'hffff, rs);
		while (pulse_out[ch] !== 1'b1)
			@(posedge aclk);
		if (src < 8)
			pin_in[src] <= 1'b1;
		else
			wr(ADDR_CTRL, cw | (32'h2 << ch), rs);
		@(posedge aclk);
		snap = dm.cnt[ch];
		chk(dir_w[ch], n > 0);
		wait_bit(ch);
		chk(32'(dm.cnt[ch] - snap), 32'(n < 0 ? -n : n));
		rd({ADDR_POS_HI, 2'(ch), 2'b00}, rv, rs);
		chk(rv, 32'(dm.pos[ch]));
		if (src < 8)
			pin_in[src] <= 1'b0;
		else
			wr(ADDR_CTRL, cw, rs);
		wr(ADDR_ICLR, 32'h1 << ch, rs);
	endtask
	// ****************************************
	// Scenarios
	// ****************************************
	task automatic t_regs;
		rd(ADDR_SEL, rv, rs);
		chk(rv, 32'hffff);
		rd(8'h44, rv, rs);
		chk(rs, RESP_SLVERR);
		wr(ADDR_ISTAT, 32'h1, rs);
		chk(rs, RESP_SLVERR);
		$display("test regs done");
	endtask
	task automatic t_paths;
		move(0, 16'sd3, 0, 1'b0, 1'b0);
		wr(ADDR_SEL, 32'hff5f, rs);
		move(1, -16'sd2, 5, 1'b1, 1'b1);
		wr(ADDR_SEL, 32'hfff8, rs);
		move(0, 16'sd2, 8, 1'b1, 1'b0);
		$display("test trigger paths done");
	endtask
	// Codes 9..F on channel 1 must refuse, flag the error and raise irq when enabled
	task automatic t_bad;
		int c0;
		for (int c = 9; c < 16; c++) begin
			c0 = dm.cnt[1];
			wr(ADDR_SEL, {16'h0, 8'hff, 4'(c), 4'hf}, rs);
			wr(ADDR_CTRL, 32'h1, rs);
			wr(8'h24, 32'h5, rs);
			repeat (150) @(posedge aclk);
			rd(ADDR_ISTAT, rv, rs);
			chk(rv[7:0], 8'h20);
			rd(ADDR_STAT, rv, rs);
			chk(rv[31:16], ERR_OP);
			chk(32'(dm.cnt[1]), 32'(c0));
			chk(irq, c > 9);
			wr(ADDR_IEN, 32'h20, rs);
			chk(irq, 1'b1);
			wr(ADDR_ICLR, 32'h20, rs);
			chk(irq, 1'b0);
		end
		$display("test bad codes done");
	endtask
	task automatic t_ch3;
		dual_adapter <= 1'b0;
		wr(ADDR_CTRL, 32'h0, rs);
		repeat (8) @(posedge aclk);
		wr(8'h2c, 32'h1, rs);
		repeat (10) @(posedge aclk);
		rd(ADDR_ISTAT, rv, rs);
		chk(rv[7:0], 8'h80);
		wr(ADDR_ICLR, 32'h80, rs);
		dual_adapter <= 1'b1;
		repeat (8) @(posedge aclk);
		move(3, 16'sd1, 3, 1'b0, 1'b0);
		move(2, -16'sd1, 2, 1'b0, 1'b0);
		$display("test channel 3 done");
	endtask
	// ****************************************
	// Run control
	// ****************************************
	task automatic test_done;
		$display("compared=%0d mismatches=%0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	initial begin
		aclk = 0;
		forever #4 aclk = ~aclk;
	end
	always @(posedge aclk) begin
		cyc++;
		if (cyc == 40000) begin
			bad_count++;
			test_done;
		end
	end
	initial begin
		{awvalid, wvalid, bready, arvalid, rready} = '0;
		{awaddr, araddr, pin_in, wdata, wstrb} = '0;
		dual_adapter = 1'b1;
		aresetn = 1'b0;
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (4) @(posedge aclk);
		t_regs;
		t_paths;
		t_bad;
		t_ch3;
		test_done;
	end
endmodule // tb_top
